// file: arp_match_params.svh
// Constants for the ARP rule matcher: register offsets, field positions,
// reset values and compare constants. Assumes one 32-bit register port.
// Operation
// (RL1) ARP criteria apply only when the entry frame type is ARP.
// (RL2) Opcode class: any, ARP only, RARP only, or other.
// (RL3) Other hits only opcodes that are neither ARP nor RARP codes.
// (RL4) Request/reply: any, ARP-or-RARP request, ARP-or-RARP reply.
// (RL5) Sender address: any, exact host, or masked network compare.
// (RL6) Target address: any, exact host, or masked network compare.
// (RL7) ARP sender hardware address equal (1) or unequal (0) to source MAC.
// (RL8) RARP target hardware address equal (1) or unequal (0) to source MAC.
// (RL9) Length check: hardware length 0x06 and protocol length 0x04.
// (RL10) Hardware space check: hardware type equals Ethernet code 1.
// (RL11) Protocol space check: protocol type equals 0x800.
// (RL12) For length and space checks, value 0 requires the fields to differ.
// (RL13) Hit only when every criterion holds; any always holds.
// (RL14) Source MAC criterion: any, or equal to a configured address.
// (RL15) On a hit apply the action: permit passes, deny drops.
`ifndef ARP_MATCH_PARAMS_SVH
`define ARP_MATCH_PARAMS_SVH

// Register byte addresses
`define REG_CTRL        8'h00
`define REG_SND_ADDR    8'h04
`define REG_SND_MASK    8'h08
`define REG_TGT_ADDR    8'h0C
`define REG_TGT_MASK    8'h10
`define REG_MAC_LO      8'h14
`define REG_MAC_HI      8'h18
`define REG_STATUS      8'h1C
`define REG_HIT_COUNT   8'h20

// Control field positions
`define CTL_FTYPE_ARP   0
`define CTL_OPCLS_LSB   1
`define CTL_REQREP_LSB  3
`define CTL_SND_LSB     5
`define CTL_TGT_LSB     7
`define CTL_SHA_LSB     9
`define CTL_THA_LSB     11
`define CTL_LEN_LSB     13
`define CTL_HRD_LSB     15
`define CTL_PRO_LSB     17
`define CTL_MAC_SPEC    19
`define CTL_DENY        20
`define CTL_WIDTH       21
`define CTL_RESET       21'h000000

// Frame field constants
`define OP_ARP_REQ      16'h0001
`define OP_ARP_REP      16'h0002
`define OP_RARP_REQ     16'h0003
`define OP_RARP_REP     16'h0004
`define HLN_ETHERNET    8'h06
`define PLN_IPV4        8'h04
`define HRD_ETHERNET    16'h0001
`define PRO_IPV4        16'h0800

`endif

// file: arp_match_pkg.sv
// Types shared by the ARP rule matcher files.
// Assumes nothing beyond a SystemVerilog compiler.
package arp_match_pkg;
    typedef enum logic [1:0] {
        OPC_ANY  = 2'b00,
        OPC_ARP  = 2'b01,
        OPC_RARP = 2'b10,
        OPC_OTHR = 2'b11
    } opclass_t;

    typedef enum logic [1:0] {
        RR_ANY   = 2'b00,
        RR_REQ   = 2'b01,
        RR_REP   = 2'b10,
        RR_RSVD  = 2'b11
    } reqrep_t;

    typedef enum logic [1:0] {
        PA_ANY   = 2'b00,
        PA_HOST  = 2'b01,
        PA_NET   = 2'b10,
        PA_RSVD  = 2'b11
    } addr_mode_t;

    // Tri-state check: any, must differ (0), must equal (1)
    typedef enum logic [1:0] {
        TRI_ANY  = 2'b00,
        TRI_ZERO = 2'b01,
        TRI_ONE  = 2'b10,
        TRI_RSVD = 2'b11
    } tri_chk_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EVAL  = 2'b01
    } eval_state_t;
endpackage : arp_match_pkg

// file: arp_frame_if.sv
// Parsed ARP frame fields passed from the top to the compare stage.
// Assumes the parser presents all fields together with one valid strobe.
`timescale 1ns/1ps
interface arp_frame_if;
    logic        valid;
    logic        is_arp;
    logic [15:0] opcode;
    logic [15:0] hrd;
    logic [15:0] pro;
    logic [7:0]  hln;
    logic [7:0]  pln;
    logic [47:0] src_mac;
    logic [47:0] sha;
    logic [47:0] tha;
    logic [31:0] spa;
    logic [31:0] tpa;

    modport src (output valid, is_arp, opcode, hrd, pro, hln, pln,
                 src_mac, sha, tha, spa, tpa);
    modport dst (input valid, is_arp, opcode, hrd, pro, hln, pln,
                 src_mac, sha, tha, spa, tpa);
endinterface : arp_frame_if

// file: arp_field_compare.sv
// Combinational compare of one frame against one rule entry.
// Assumes the configuration is held stable by the caller.
`timescale 1ns/1ps
`include "arp_match_params.svh"
module arp_field_compare
(
    // Frame fields
    arp_frame_if.dst                       frm,
    // Rule configuration
    input  wire logic [`CTL_WIDTH-1:0]    ctrl,
    input  wire logic [31:0]              snd_addr,
    input  wire logic [31:0]              snd_mask,
    input  wire logic [31:0]              tgt_addr,
    input  wire logic [31:0]              tgt_mask,
    input  wire logic [47:0]              mac_val,
    // Result
    output      logic                     hit
);

    // Masked or exact protocol address compare, used for sender and target
    function automatic logic addr_ok(input logic [1:0] mode, input logic [31:0] val,
                                     input logic [31:0] cfg, input logic [31:0] msk);
        case (arp_match_pkg::addr_mode_t'(mode))
            arp_match_pkg::PA_ANY:  addr_ok = 1'b1;
            arp_match_pkg::PA_HOST: addr_ok = (val == cfg);
            arp_match_pkg::PA_NET:  addr_ok = ((val & msk) == (cfg & msk));
            default:                addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    // Tri-state check against a compare outcome; reserved code never hits
    function automatic logic tri_ok(input logic [1:0] mode, input logic eq);
        case (arp_match_pkg::tri_chk_t'(mode))
            arp_match_pkg::TRI_ANY:  tri_ok = 1'b1;
            arp_match_pkg::TRI_ZERO: tri_ok = !eq; // see RL12
            arp_match_pkg::TRI_ONE:  tri_ok = eq;
            default:                 tri_ok = 1'b0;
        endcase
    endfunction : tri_ok

    logic op_arp;
    logic op_rarp;
    logic op_req;
    logic op_rep;
    logic c_opc;
    logic c_rr;
    logic c_sha;
    logic c_tha;
    logic arp_all;

    // Opcode decode
    assign op_arp  = (frm.opcode == `OP_ARP_REQ) || (frm.opcode == `OP_ARP_REP);
    assign op_rarp = (frm.opcode == `OP_RARP_REQ) || (frm.opcode == `OP_RARP_REP);
    assign op_req  = (frm.opcode == `OP_ARP_REQ) || (frm.opcode == `OP_RARP_REQ); // see RL4
    assign op_rep  = (frm.opcode == `OP_ARP_REP) || (frm.opcode == `OP_RARP_REP); // see RL4

    // Opcode class
    always_comb
    begin
        case (arp_match_pkg::opclass_t'(ctrl[`CTL_OPCLS_LSB +: 2]))
            arp_match_pkg::OPC_ANY:  c_opc = 1'b1;               // see RL2
            arp_match_pkg::OPC_ARP:  c_opc = op_arp;             // see RL2
            arp_match_pkg::OPC_RARP: c_opc = op_rarp;            // see RL2
            default:                 c_opc = !op_arp && !op_rarp; // see RL3
        endcase
    end

    // Request or reply
    always_comb
    begin
        case (arp_match_pkg::reqrep_t'(ctrl[`CTL_REQREP_LSB +: 2]))
            arp_match_pkg::RR_ANY: c_rr = 1'b1;
            arp_match_pkg::RR_REQ: c_rr = op_req; // see RL4
            arp_match_pkg::RR_REP: c_rr = op_rep; // see RL4
            default:               c_rr = 1'b0;
        endcase
    end

    // Hardware address checks, when set, pass only frames of their own opcode class and reject all others
    assign c_sha = (ctrl[`CTL_SHA_LSB +: 2] == 2'b00)
                   || (op_arp && tri_ok(ctrl[`CTL_SHA_LSB +: 2], frm.sha == frm.src_mac)); // see RL7
    assign c_tha = (ctrl[`CTL_THA_LSB +: 2] == 2'b00)
                   || (op_rarp && tri_ok(ctrl[`CTL_THA_LSB +: 2], frm.tha == frm.src_mac)); // see RL8

    // All criteria combined
    assign arp_all = c_opc && c_rr && c_sha && c_tha
        && addr_ok(ctrl[`CTL_SND_LSB +: 2], frm.spa, snd_addr, snd_mask)  // see RL5
        && addr_ok(ctrl[`CTL_TGT_LSB +: 2], frm.tpa, tgt_addr, tgt_mask)  // see RL6
        && tri_ok(ctrl[`CTL_LEN_LSB +: 2],
                  (frm.hln == `HLN_ETHERNET) && (frm.pln == `PLN_IPV4))   // see RL9
        && tri_ok(ctrl[`CTL_HRD_LSB +: 2], frm.hrd == `HRD_ETHERNET)      // see RL10
        && tri_ok(ctrl[`CTL_PRO_LSB +: 2], frm.pro == `PRO_IPV4);         // see RL11

    // ARP criteria apply only to ARP-typed entries and ARP frames
    assign hit = frm.is_arp && (!ctrl[`CTL_FTYPE_ARP] || arp_all)   // see RL1
                 && (!ctrl[`CTL_MAC_SPEC] || frm.src_mac == mac_val); // see RL14 RL13

endmodule : arp_field_compare

// file: arp_field_rule_matcher.sv
// Top of the ARP rule matcher: register port, frame capture and verdict.
// Assumes the ingress parser hands over decoded ARP fields with a strobe.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "arp_match_params.svh"
module arp_field_rule_matcher
(
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output      logic [31:0] reg_rdata_ff,
    // Frame from parser
    input  wire logic        frm_valid,
    input  wire logic        frm_is_arp,
    input  wire logic [15:0] frm_opcode,
    input  wire logic [15:0] frm_hrd,
    input  wire logic [15:0] frm_pro,
    input  wire logic [7:0]  frm_hln,
    input  wire logic [7:0]  frm_pln,
    input  wire logic [47:0] frame_source_hw_address,
    input  wire logic [47:0] frm_sha,
    input  wire logic [47:0] frm_tha,
    input  wire logic [31:0] sender_protocol_address_field,
    input  wire logic [31:0] frm_tpa,
    // Verdict
    output      logic        res_valid_ff,
    output      logic        res_hit_ff,
    output      logic        res_permit_ff,
    output      logic        res_drop_ff
);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [`CTL_WIDTH-1:0] ctrl_ff;
    logic [31:0]           snd_addr_ff;
    logic [31:0]           snd_mask_ff;
    logic [31:0]           tgt_addr_ff;
    logic [31:0]           tgt_mask_ff;
    logic [47:0]           mac_ff;
    logic [31:0]           hit_cnt_ff;
    logic                  last_hit_ff;
    logic                  cmp_hit;
    arp_match_pkg::eval_state_t state_ff;
    arp_match_pkg::eval_state_t nxt_state;

    arp_frame_if frm_bus ();

    // Software writes; sizes kept at the field width
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl_ff     <= `CTL_RESET;
            snd_addr_ff <= 32'h00000000;
            snd_mask_ff <= 32'h00000000;
            tgt_addr_ff <= 32'h00000000;
            tgt_mask_ff <= 32'h00000000;
            mac_ff      <= 48'h000000000000;
        end
        else if (clk_en && reg_wr)
        begin
            case (reg_addr)
                `REG_CTRL:     ctrl_ff          <= reg_wdata[`CTL_WIDTH-1:0];
                `REG_SND_ADDR: snd_addr_ff      <= reg_wdata;
                `REG_SND_MASK: snd_mask_ff      <= reg_wdata;
                `REG_TGT_ADDR: tgt_addr_ff      <= reg_wdata;
                `REG_TGT_MASK: tgt_mask_ff      <= reg_wdata;
                `REG_MAC_LO:   mac_ff[31:0]     <= reg_wdata;
                `REG_MAC_HI:   mac_ff[47:32]    <= reg_wdata[15:0];
                default:       ;
            endcase
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            reg_rdata_ff <= 32'h00000000;
        else if (clk_en)
        begin
            if (!reg_rd)
                reg_rdata_ff <= 32'h00000000;
            else
            begin
                case (reg_addr)
                    `REG_CTRL:      reg_rdata_ff <= {11'h000, ctrl_ff};
                    `REG_SND_ADDR:  reg_rdata_ff <= snd_addr_ff;
                    `REG_SND_MASK:  reg_rdata_ff <= snd_mask_ff;
                    `REG_TGT_ADDR:  reg_rdata_ff <= tgt_addr_ff;
                    `REG_TGT_MASK:  reg_rdata_ff <= tgt_mask_ff;
                    `REG_MAC_LO:    reg_rdata_ff <= mac_ff[31:0];
                    `REG_MAC_HI:    reg_rdata_ff <= {16'h0000, mac_ff[47:32]};
                    `REG_STATUS:    reg_rdata_ff <= {31'h00000000, last_hit_ff};
                    `REG_HIT_COUNT: reg_rdata_ff <= hit_cnt_ff;
                    default:        reg_rdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame capture: one register stage keeps the compare off the parser path
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            frm_bus.valid   <= 1'b0;
            frm_bus.is_arp  <= 1'b0;
            frm_bus.opcode  <= 16'h0000;
            frm_bus.hrd     <= 16'h0000;
            frm_bus.pro     <= 16'h0000;
            frm_bus.hln     <= 8'h00;
            frm_bus.pln     <= 8'h00;
            frm_bus.src_mac <= 48'h000000000000;
            frm_bus.sha     <= 48'h000000000000;
            frm_bus.tha     <= 48'h000000000000;
            frm_bus.spa     <= 32'h00000000;
            frm_bus.tpa     <= 32'h00000000;
        end
        else if (clk_en)
        begin
            frm_bus.valid <= frm_valid;
            if (frm_valid)
            begin
                frm_bus.is_arp  <= frm_is_arp;
                frm_bus.opcode  <= frm_opcode;
                frm_bus.hrd     <= frm_hrd;
                frm_bus.pro     <= frm_pro;
                frm_bus.hln     <= frm_hln;
                frm_bus.pln     <= frm_pln;
                frm_bus.src_mac <= frame_source_hw_address;
                frm_bus.sha     <= frm_sha;
                frm_bus.tha     <= frm_tha;
                frm_bus.spa     <= sender_protocol_address_field;
                frm_bus.tpa     <= frm_tpa;
            end
        end
    end

    // Compare stage
    arp_field_compare u_cmp
    (
        .frm      (frm_bus),
        .ctrl     (ctrl_ff),
        .snd_addr (snd_addr_ff),
        .snd_mask (snd_mask_ff),
        .tgt_addr (tgt_addr_ff),
        .tgt_mask (tgt_mask_ff),
        .mac_val  (mac_ff),
        .hit      (cmp_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Evaluation state: idle until a captured frame waits
    always_comb
    begin
        case (state_ff)
            arp_match_pkg::ST_IDLE: nxt_state = frm_bus.valid ? arp_match_pkg::ST_EVAL
                                                              : arp_match_pkg::ST_IDLE;
            arp_match_pkg::ST_EVAL: nxt_state = frm_bus.valid ? arp_match_pkg::ST_EVAL
                                                              : arp_match_pkg::ST_IDLE;
            default:                nxt_state = arp_match_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            state_ff <= arp_match_pkg::ST_IDLE;
        else if (clk_en)
            state_ff <= nxt_state;
    end

    // Verdict: one-cycle pulses two edges after the frame strobe
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            res_valid_ff  <= 1'b0;
            res_hit_ff    <= 1'b0;
            res_permit_ff <= 1'b0;
            res_drop_ff   <= 1'b0;
        end
        else if (clk_en)
        begin
            res_valid_ff  <= frm_bus.valid;
            res_hit_ff    <= frm_bus.valid && cmp_hit;                       // see RL13
            res_permit_ff <= frm_bus.valid && cmp_hit && !ctrl_ff[`CTL_DENY]; // see RL15
            res_drop_ff   <= frm_bus.valid && cmp_hit && ctrl_ff[`CTL_DENY];  // see RL15
        end
    end

    // Hit counter and last-result status, read-only
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            hit_cnt_ff  <= 32'h00000000;
            last_hit_ff <= 1'b0;
        end
        else if (clk_en && frm_bus.valid)
        begin
            last_hit_ff <= cmp_hit;
            if (cmp_hit)
                hit_cnt_ff <= hit_cnt_ff + 32'h00000001; // Wraps silently
        end
    end

endmodule : arp_field_rule_matcher

// file: parser_model.sv
// Ingress parser stand-in that hands one parsed frame to the matcher.
// Assumes the bench raises go for one cycle per frame, in step with clk_sys.
`timescale 1ns/1ps
package frame_gen_pkg;
    typedef struct packed {
        logic        arp;
        logic [15:0] op;
        logic [15:0] hrd;
        logic [15:0] pro;
        logic [7:0]  hln;
        logic [7:0]  pln;
        logic [47:0] src;
        logic [47:0] sha;
        logic [47:0] tha;
        logic [31:0] spa;
        logic [31:0] tpa;
    } frame_t;
endpackage : frame_gen_pkg
////////////////////////////////////////
module parser_model
(
    // Clock and request
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  go,
    input  wire frame_gen_pkg::frame_t frame_in,
    // Toward the matcher
    output      logic                  frm_valid_ff,
    output      frame_gen_pkg::frame_t frame_ff
);
    // Fields valid for one cycle only; afterwards every bit toggles each cycle while go stays low, so old values return every second cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            frm_valid_ff <= 1'b0;
            frame_ff     <= '0;
        end
        else
        begin
            frm_valid_ff <= go;
            frame_ff     <= go ? frame_in : ~frame_ff;
        end
    end
endmodule : parser_model

// file: arp_match_props.sv
// Port-level checks on the ARP rule matcher.
// Assumes one clock domain with asynchronous active-high reset.
`timescale 1ns/1ps
module arp_match_props
(
    // Clock, reset, enable
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        clk_en,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    // Frame and verdict
    input wire logic        frm_valid,
    input wire logic        frm_is_arp,
    input wire logic        res_valid_ff,
    input wire logic        res_hit_ff,
    input wire logic        res_permit_ff,
    input wire logic        res_drop_ff
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // Verdict timing and qualification
    AST_VALID_LAT: assert property ((frm_valid && clk_en) ##1 clk_en |=> res_valid_ff)
        else $error("verdict missing two cycles after frame");
    AST_PULSE: assert property (res_valid_ff && clk_en && $past(clk_en) && !$past(frm_valid)
        |=> !res_valid_ff)
        else $error("verdict without a frame");
    AST_HIT_VALID: assert property (res_hit_ff |-> res_valid_ff)
        else $error("hit outside a verdict");
    AST_NON_ARP: assert property ((frm_valid && clk_en && !frm_is_arp) ##1 clk_en
        |=> !res_hit_ff)
        else $error("non-ARP frame hit");
    // Action follows a hit, exactly one of the two
    AST_ACTION_ONE: assert property (res_hit_ff |-> (res_permit_ff ^ res_drop_ff))
        else $error("hit without one action");
    AST_ACTION_HIT: assert property ((res_permit_ff || res_drop_ff) |-> res_hit_ff)
        else $error("action without hit");
    // Register port answers only in the cycle after a read
    AST_RD_IDLE: assert property ((clk_en && !reg_rd) |=> reg_rdata_ff == 32'h00000000)
        else $error("read data outside read cycle");
    AST_UNMAPPED: assert property ((clk_en && reg_rd && reg_addr > 8'h20)
        |=> reg_rdata_ff == 32'h00000000)
        else $error("unmapped read not zero");
    AST_FREEZE: assert property (!clk_en |=> $stable(res_valid_ff) && $stable(reg_rdata_ff))
        else $error("state moved while frozen");
    C_DROP: cover property (res_hit_ff && res_drop_ff);
    C_PERMIT: cover property (res_hit_ff && res_permit_ff);
    C_MISS: cover property (res_valid_ff && !res_hit_ff);
endmodule : arp_match_props

bind arp_field_rule_matcher arp_match_props i_arp_match_props
(
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .frm_valid(frm_valid), .frm_is_arp(frm_is_arp),
    .res_valid_ff(res_valid_ff), .res_hit_ff(res_hit_ff),
    .res_permit_ff(res_permit_ff), .res_drop_ff(res_drop_ff)
);

// file: tb_top.sv
// Self-checking bench for the ARP rule matcher.
// Assumes the parser model and checker files are compiled first.
`timescale 1ns/1ps
`include "arp_match_params.svh"
module tb_top;
    logic                  clk_sys;
    logic                  rst;
    logic                  clk_en;
    logic [7:0]            reg_addr;
    logic [31:0]           reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [31:0]           reg_rdata_ff;
    logic                  go;
    logic                  frm_valid_ff;
    frame_gen_pkg::frame_t f;
    frame_gen_pkg::frame_t pf;
    wire logic [3:0]       res;
    logic [31:0]           hits;
    logic [47:0]           mac;
    logic [31:0]           ip [4];
    logic [31:0]           msk;
    int                    fails;
    int                    cmp_count;

    parser_model i_parser_model
    (
        .clk_sys(clk_sys), .rst(rst), .go(go), .frame_in(f),
        .frm_valid_ff(frm_valid_ff), .frame_ff(pf)
    );
    arp_field_rule_matcher i_arp_field_rule_matcher
    (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .frm_valid(frm_valid_ff), .frm_is_arp(pf.arp), .frm_opcode(pf.op), .frm_hrd(pf.hrd),
        .frm_pro(pf.pro), .frm_hln(pf.hln), .frm_pln(pf.pln), .frame_source_hw_address(pf.src),
        .frm_sha(pf.sha), .frm_tha(pf.tha), .sender_protocol_address_field(pf.spa),
        .frm_tpa(pf.tpa), .res_valid_ff(res[3]), .res_hit_ff(res[2]),
        .res_permit_ff(res[1]), .res_drop_ff(res[0])
    );
    ////////////////////////////////////////
    // Clock and hang guard
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (50000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end
    ////////////////////////////////////////
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : compare
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 compare(reg_rdata_ff, exp);
    endtask : rd
    // Verdict stands only two cycles after the taking edge, so sample exactly there
    task automatic send(input logic h, input logic deny);
        @(posedge clk_sys);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 compare({28'h0, res}, {28'h0, 1'b1, h, h & ~deny, h & deny});
        hits = hits + {31'h0, h};
    endtask : send
    task automatic base();
        f     = '0;
        f.arp = 1'b1;
        f.op  = `OP_ARP_REQ;
        f.hrd = `HRD_ETHERNET;
        f.pro = `PRO_IPV4;
        f.hln = `HLN_ETHERNET;
        f.pln = `PLN_IPV4;
        f.src = mac;
        f.sha = mac;
        f.tha = mac;
    endtask : base
    function automatic logic exp_op(input int c, input int r, input int o);
        logic a;
        logic q;
        a = (o == 1 || o == 2);
        q = (o == 3 || o == 4);
        return (c == 0 || (c == 1 && a) || (c == 2 && q) || (c == 3 && !a && !q))
            && (r == 0 || (r == 1 && (o == 1 || o == 3)) || (r == 2 && (o == 2 || o == 4)));
    endfunction : exp_op
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////
    initial
    begin
        {rst, clk_en, go, reg_wr, reg_rd} = 5'b11000;
        {reg_addr, reg_wdata, f, hits, fails, cmp_count} = '0;
        mac = 48'h02AA55000001;
        ip  = '{32'hC0A80101, 32'hC0A80177, 32'hC0A8FF01, 32'hC0A90101};
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values, read-only and unmapped places, frozen write
        for (int a = 0; a <= 32; a += 4)
            rd(8'(a), 32'h0);
        rd(8'h40, 32'h0);
        wr(`REG_CTRL, 32'hFFFFFFFF);
        rd(`REG_CTRL, 32'h001FFFFF);
        wr(`REG_STATUS, 32'h1);
        rd(`REG_STATUS, 32'h0);
        clk_en <= 1'b0;
        wr(`REG_TGT_ADDR, 32'h12345678);
        clk_en <= 1'b1;
        rd(`REG_TGT_ADDR, 32'h0);
        wr(`REG_MAC_LO, 32'h55000001);
        wr(`REG_MAC_HI, 32'h000002AA);
        $display("registers done");
        // Non-ARP entry ignores ARP criteria
        wr(`REG_CTRL, 32'h00000004);
        base();
        send(1'b1, 1'b0);
        f.arp = 1'b0;
        send(1'b0, 1'b0);
        $display("frame type done");
        // Opcode class against request or reply, every setting
        base();
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++)
            begin
                wr(`REG_CTRL, 32'(1 + 2 * c + 8 * r));
                for (int o = 1; o <= 5; o++)
                begin
                    f.op = 16'(o);
                    send(exp_op(c, r, o), 1'b0);
                end
            end
        $display("opcode done");
        // Sender and target address, host and masked network
        wr(`REG_SND_ADDR, ip[0]);
        wr(`REG_SND_MASK, 32'hFFFFFF00);
        wr(`REG_TGT_ADDR, ip[0]);
        wr(`REG_TGT_MASK, 32'hFFFF0000);
        for (int s = 0; s < 2; s++)
            for (int m = 0; m < 4; m++)
            begin
                wr(`REG_CTRL, 32'(1 + (m << (5 + 2 * s))));
                msk = s ? 32'hFFFF0000 : 32'hFFFFFF00;
                for (int k = 0; k < 4; k++)
                begin
                    base();
                    if (s == 0) f.spa = ip[k]; else f.tpa = ip[k];
                    send(m == 0 || (m == 1 && k == 0) || (m == 2 && ((ip[k] ^ ip[0]) & msk) == 0),
                         1'b0);
                end
            end
        $display("address done");
        // Sender and target hardware address against source MAC
        for (int t = 0; t < 2; t++)
            for (int v = 1; v < 4; v++)
            begin
                wr(`REG_CTRL, 32'(1 + (v << (9 + 2 * t))));
                for (int j = 0; j < 4; j++)
                begin
                    base();
                    f.op = j[1] ? `OP_RARP_REQ : `OP_ARP_REQ;
                    if (t == 0) f.sha = j[0] ? mac : ~mac; else f.tha = j[0] ? mac : ~mac;
                    send(v != 3 && j[1] == t[0] && j[0] == (v == 2), 1'b0);
                end
            end
        $display("hardware address done");
        // Length and space checks, must-equal and must-differ
        for (int g = 0; g < 3; g++)
            for (int v = 1; v < 4; v++)
            begin
                wr(`REG_CTRL, 32'(1 + (v << (13 + 2 * g))));
                for (int b = 0; b < 3; b++)
                begin
                    base();
                    if (b == 1 && g == 0) f.pln = 8'h10;
                    if (b == 2 && g == 0) f.hln = 8'h08;
                    if (b > 0 && g == 1) f.hrd = 16'h0006;
                    if (b > 0 && g == 2) f.pro = 16'h86DD;
                    send(v != 3 && (v == 2) == (b == 0), 1'b0);
                end
            end
        $display("header checks done");
        // Specific source MAC with deny action, then status and count
        wr(`REG_CTRL, 32'h00180001);
        base();
        f.src = mac ^ 48'h000000000001;
        send(1'b0, 1'b1);
        f.src = mac ^ 48'h010000000000;
        send(1'b0, 1'b1);
        f.src = mac;
        send(1'b1, 1'b1);
        rd(`REG_STATUS, 32'h1);
        rd(`REG_HIT_COUNT, hits);
        $display("action and count done");
        give_verdict();
    end
endmodule : tb_top
